// ==== hdl/eru_record.sv ====
// One standard error record with priority-based update on error reports.
// Reporters are logic on clk_sys; software reads and clears through
// plain strobes. A read snapshot guards clears against stale writes.
`timescale 1ns/1ns
`include "eru_cfg.svh"
module eru_record
   import eru_pkg::*;
#(
   parameter int NSRC = 2,
   parameter int CODE_W = 8,
   parameter int ADDR_W = 32,
   parameter int MISC_W = 32,
   parameter int TS_W = 32,
   parameter int CNT_W = 8,
   parameter bit HAS_CNT = 1'b1,
   parameter bit HAS_TS = 1'b1,
   parameter bit KEEP_MISC = 1'b1
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [NSRC-1:0] errValid,
   input wire logic [NSRC-1:0][2:0] errKind,
   input wire logic [NSRC-1:0][1:0] errCeVal,
   input wire logic [NSRC-1:0][CODE_W-1:0] errPrimaryCode,
   input wire logic [NSRC-1:0][CODE_W-1:0] errImplCode,
   input wire logic [NSRC-1:0][CODE_W-1:0] errArchCode,
   input wire logic [NSRC-1:0] errPoisonSeen,
   input wire logic [NSRC-1:0] errHasAddr,
   input wire logic [NSRC-1:0][ADDR_W-1:0] errAddr,
   input wire logic [NSRC-1:0] errHasMisc,
   input wire logic [NSRC-1:0][MISC_W-1:0] errMisc,
   input wire logic [NSRC-1:0] errMiscUnrelated,
   input wire logic countedOverwriteOption,
   input wire logic swStatusRead,
   input wire logic swClear,
   input wire logic [`ERU_CLR_W-1:0] swClearMask,
   output logic statusValid_r,
   output logic [1:0] ceField_r,
   output logic postponedFlag_r,
   output logic uncorrectedFlag_r,
   output logic [1:0] uncorrectedSubtype_r,
   output logic overflowFlag_r,
   output logic [CODE_W-1:0] primaryCode_r,
   output logic poisonSeen_r,
   output logic [CODE_W-1:0] implFaultCode_r,
   output logic [CODE_W-1:0] archFaultCode_r,
   output logic addrValid_r,
   output logic [ADDR_W-1:0] addr_r,
   output logic miscValid_r,
   output logic [MISC_W-1:0] misc_r,
   output logic [TS_W-1:0] timestamp_r,
   output logic [CNT_W-1:0] ceCount_r,
   output logic clearIgnored_r
);

   // Selected report for this cycle.
   logic rec; // Some report is being recorded now.
   eru_kind_t selKind; // Kind of the winning report.
   int unsigned selIdx; // Index of the winning report.
   logic [2:0] bestRank; // Rank of the winning report so far.

   // Action decided for the selected report.
   logic [2:0] prevRank; // Rank of the stored state.
   logic ovw; // Overwrite the syndrome.
   logic setOf; // Action forces overflow to one.
   logic doCount; // Action counts the error.
   logic cntWrap; // Counting now wraps the counter.
   logic cntInc; // Counter increment strobe.

   // Software guard state.
   logic touched_r; // Record changed since the last status read.
   logic touched_nxt;
   logic clrTake; // A clear is accepted this cycle.
   logic clearIgnored_nxt;

   // Free-running time base for timestamps.
   logic [TS_W-1:0] tsBase_r;
   logic [TS_W-1:0] tsBase_nxt;

   // Next values of the record fields.
   logic statusValid_nxt;
   logic [1:0] ceField_nxt;
   logic postponedFlag_nxt;
   logic uncorrectedFlag_nxt;
   logic [1:0] uncorrectedSubtype_nxt;
   logic overflowFlag_nxt;
   logic [CODE_W-1:0] primaryCode_nxt;
   logic poisonSeen_nxt;
   logic [CODE_W-1:0] implFaultCode_nxt;
   logic [CODE_W-1:0] archFaultCode_nxt;
   logic addrValid_nxt;
   logic [ADDR_W-1:0] addr_nxt;
   logic miscValid_nxt;
   logic [MISC_W-1:0] misc_nxt;
   logic [TS_W-1:0] timestamp_nxt;
   logic [1:0] ceEff; // Nonzero corrected value for the winner.

   // Pick the single highest priority report among the reporters.
   // Lower ones in the same cycle are dropped and not counted; this
   // keeps one update per cycle and no queue of pending reports.
   always_comb begin
      rec = 1'b0;
      selIdx = 0;
      bestRank = `ERU_RANK_NONE;
      for (int i = 0; i < NSRC; i++) begin
         if (errValid[i] && eruRank(eru_kind_t'(errKind[i])) > bestRank) begin
            rec = 1'b1;
            selIdx = i;
            bestRank = eruRank(eru_kind_t'(errKind[i]));
         end
      end
      selKind = eru_kind_t'(errKind[selIdx]);
      ceEff = (errCeVal[selIdx] == 2'h0) ? `ERU_CE_DEFAULT : errCeVal[selIdx];
   end

   // Table decode lives in its own module so it can be reused per record.
   eru_action_sel #(
      .HAS_CNT(HAS_CNT)
   ) uAction (
      .prevValid(statusValid_r),
      .prevCe(ceField_r),
      .prevPostponed(postponedFlag_r),
      .prevUncorr(uncorrectedFlag_r),
      .prevSub(uncorrectedSubtype_r),
      .newKind(selKind),
      .ceoOpt(countedOverwriteOption),
      .ofNow(overflowFlag_r),
      .prevRank(prevRank),
      .overwrite(ovw),
      .setOf(setOf),
      .doCount(doCount)
   );

   assign cntInc = rec && doCount;

   // Corrected error counter; absent counters are never incremented.
   eru_ce_counter #(
      .CNT_W(CNT_W)
   ) uCount (
      .clk_sys(clk_sys),
      .rst(rst),
      .inc(cntInc),
      .count_r(ceCount_r),
      .wrapNext(cntWrap)
   );

   // Software clear guard. A report in the same cycle as a clear counts
   // as an update, so the recording wins over the clear.
   always_comb begin
      touched_nxt = touched_r;
      if (swStatusRead) begin
         touched_nxt = 1'b0;
      end
      if (rec) begin
         touched_nxt = 1'b1;
      end
      clrTake = swClear && !touched_r && !rec;
      clearIgnored_nxt = swClear && !clrTake;
      tsBase_nxt = tsBase_r + TS_W'(1);
   end

   // Record field update: first software clears, then the new report.
   always_comb begin
      statusValid_nxt = statusValid_r;
      ceField_nxt = ceField_r;
      postponedFlag_nxt = postponedFlag_r;
      uncorrectedFlag_nxt = uncorrectedFlag_r;
      uncorrectedSubtype_nxt = uncorrectedSubtype_r;
      overflowFlag_nxt = overflowFlag_r;
      primaryCode_nxt = primaryCode_r;
      poisonSeen_nxt = poisonSeen_r;
      implFaultCode_nxt = implFaultCode_r;
      archFaultCode_nxt = archFaultCode_r;
      addrValid_nxt = addrValid_r;
      addr_nxt = addr_r;
      miscValid_nxt = miscValid_r;
      misc_nxt = misc_r;
      timestamp_nxt = timestamp_r;
      if (clrTake) begin
         // Write-one-to-clear of the chosen status bits.
         if (swClearMask[`ERU_CLR_VALID]) statusValid_nxt = 1'b0;
         if (swClearMask[`ERU_CLR_CE]) ceField_nxt = 2'h0;
         if (swClearMask[`ERU_CLR_POSTPONED]) postponedFlag_nxt = 1'b0;
         if (swClearMask[`ERU_CLR_UNCORR]) uncorrectedFlag_nxt = 1'b0;
         if (swClearMask[`ERU_CLR_OVERFLOW]) overflowFlag_nxt = 1'b0;
         if (swClearMask[`ERU_CLR_MISC]) miscValid_nxt = 1'b0;
         if (swClearMask[`ERU_CLR_ADDR]) addrValid_nxt = 1'b0;
      end
      if (rec) begin
         if (setOf) begin
            overflowFlag_nxt = 1'b1;
         end
         if (cntInc && cntWrap) begin
            overflowFlag_nxt = 1'b1;
         end
         if (ovw) begin
            statusValid_nxt = 1'b1;
            case (selKind)
               KIND_CE: begin
                  ceField_nxt = ceEff;
                  postponedFlag_nxt = 1'b0;
                  uncorrectedFlag_nxt = 1'b0;
               end
               KIND_DE: begin
                  postponedFlag_nxt = 1'b1;
                  uncorrectedFlag_nxt = 1'b0;
               end
               default: begin
                  uncorrectedFlag_nxt = 1'b1;
               end
            endcase
            case (selKind)
               KIND_RESTART: uncorrectedSubtype_nxt = `ERU_SUB_RESTART;
               KIND_RECOVER: uncorrectedSubtype_nxt = `ERU_SUB_RECOVER;
               KIND_UNRECOV: uncorrectedSubtype_nxt = `ERU_SUB_UNRECOV;
               KIND_UNCONT: uncorrectedSubtype_nxt = `ERU_SUB_UNCONT;
               default: uncorrectedSubtype_nxt = uncorrectedSubtype_r;
            endcase
            primaryCode_nxt = errPrimaryCode[selIdx];
            implFaultCode_nxt = errImplCode[selIdx];
            archFaultCode_nxt = errArchCode[selIdx];
            poisonSeen_nxt = errPoisonSeen[selIdx] && (selKind != KIND_CE);
            addrValid_nxt = errHasAddr[selIdx];
            addr_nxt = errHasAddr[selIdx] ? errAddr[selIdx] : addr_r;
            if (HAS_TS) begin
               timestamp_nxt = tsBase_r;
            end
            if (errHasMisc[selIdx]) begin
               misc_nxt = errMisc[selIdx];
            end
            if (HAS_TS || errHasMisc[selIdx]) begin
               miscValid_nxt = 1'b1;
            end else if (!errMiscUnrelated[selIdx]) begin
               miscValid_nxt = 1'b0;
            end
         end else begin
            case (selKind)
               KIND_CE: ceField_nxt = ceEff;
               KIND_DE: postponedFlag_nxt = 1'b1;
               default: uncorrectedFlag_nxt = 1'b1;
            endcase
            if (KEEP_MISC && errHasMisc[selIdx]) begin
               misc_nxt = errMisc[selIdx];
               miscValid_nxt = 1'b1;
            end
         end
      end
   end

   // Register every record field except the count, and every guard bit.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         statusValid_r <= 1'b0;
         ceField_r <= 2'h0;
         postponedFlag_r <= 1'b0;
         uncorrectedFlag_r <= 1'b0;
         uncorrectedSubtype_r <= 2'h0;
         overflowFlag_r <= 1'b0;
         primaryCode_r <= '0;
         poisonSeen_r <= 1'b0;
         implFaultCode_r <= '0;
         archFaultCode_r <= '0;
         addrValid_r <= 1'b0;
         addr_r <= '0;
         miscValid_r <= 1'b0;
         misc_r <= '0;
         timestamp_r <= '0;
         touched_r <= 1'b0;
         clearIgnored_r <= 1'b0;
         tsBase_r <= '0;
      end else begin
         statusValid_r <= statusValid_nxt;
         ceField_r <= ceField_nxt;
         postponedFlag_r <= postponedFlag_nxt;
         uncorrectedFlag_r <= uncorrectedFlag_nxt;
         uncorrectedSubtype_r <= uncorrectedSubtype_nxt;
         overflowFlag_r <= overflowFlag_nxt;
         primaryCode_r <= primaryCode_nxt;
         poisonSeen_r <= poisonSeen_nxt;
         implFaultCode_r <= implFaultCode_nxt;
         archFaultCode_r <= archFaultCode_nxt;
         addrValid_r <= addrValid_nxt;
         addr_r <= addr_nxt;
         miscValid_r <= miscValid_nxt;
         misc_r <= misc_nxt;
         timestamp_r <= timestamp_nxt;
         touched_r <= touched_nxt;
         clearIgnored_r <= clearIgnored_nxt;
         tsBase_r <= tsBase_nxt;
      end
   end

   // Checks on the update behaviour, all on clk_sys.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   ovw_valid_a: assert property (rec && ovw |=> statusValid_r)
      else $error("Overwrite left record invalid.");
   ovw_code_a: assert property (rec && ovw |=>
      primaryCode_r == $past(errPrimaryCode[selIdx]))
      else $error("Overwrite did not store primary code.");
   keep_syn_a: assert property (rec && !ovw |=>
      $stable(primaryCode_r) && $stable(addrValid_r) && $stable(timestamp_r))
      else $error("Keep changed syndrome fields.");
   force_of_a: assert property (rec && setOf |=> overflowFlag_r)
      else $error("Overflow not set by overflow action.");
   plain_of_a: assert property (rec && ovw && !setOf && !doCount && !clrTake
      |=> overflowFlag_r == $past(overflowFlag_r))
      else $error("Plain overwrite changed overflow.");
   wrap_of_a: assert property (cntInc && cntWrap |=>
      overflowFlag_r && ceCount_r == '0)
      else $error("Counter wrap did not set overflow.");
   addr_valid_a: assert property (rec && ovw |=>
      addrValid_r == $past(errHasAddr[selIdx]))
      else $error("Address valid mismatch on overwrite.");
   poison_rec_a: assert property (rec && ovw && selKind == KIND_CE |=> !poisonSeen_r)
      else $error("Poison set for corrected error.");
   empty_ovw_a: assert property (rec && prevRank == `ERU_RANK_NONE |-> ovw)
      else $error("Empty record not overwritten.");
   prio_keep_a: assert property (rec && prevRank >= `ERU_RANK_DE &&
      selKind != KIND_CE && eruRank(selKind) <= prevRank |-> !ovw && setOf)
      else $error("Lower priority error overwrote record.");
   stale_clr_a: assert property (swClear && touched_r && !rec |=>
      $stable(statusValid_r) && clearIgnored_r)
      else $error("Stale clear was not ignored.");

   keep_over_c: cover property (rec && !ovw && setOf);
   wrap_c: cover property (cntInc && cntWrap);
   stale_c: cover property (swClear && touched_r);
   uncont_c: cover property (rec && ovw && selKind == KIND_UNCONT);
endmodule

// ==== pkg/eru_cfg.svh ====
// Constants for the error record update logic: priority ranks, field
// positions and fixed encodings. Included by eru_record, eru_action_sel and the bench.
// Assumes nothing of the includer; the defines use no types.
`ifndef ERU_CFG_SVH
`define ERU_CFG_SVH
// Sub-type encodings of the uncorrected states.
`define ERU_SUB_RESTART 2'h2
`define ERU_SUB_RECOVER 2'h3
`define ERU_SUB_UNRECOV 2'h1
`define ERU_SUB_UNCONT 2'h0
// Corrected field value used when a reporter gives zero.
`define ERU_CE_DEFAULT 2'h1
// Bit positions inside the software clear mask.
`define ERU_CLR_VALID 0
`define ERU_CLR_CE 1
`define ERU_CLR_POSTPONED 2
`define ERU_CLR_UNCORR 3
`define ERU_CLR_OVERFLOW 4
`define ERU_CLR_MISC 5
`define ERU_CLR_ADDR 6
`define ERU_CLR_W 7
// Priority ranks: empty record, then corrected upward.
`define ERU_RANK_NONE 3'h0
`define ERU_RANK_CE 3'h1
`define ERU_RANK_DE 3'h2
`endif

// ==== pkg/eru_pkg.sv ====
// Types shared by the error record update logic.
// Assumes nothing of its surroundings.
package eru_pkg;
   // Kind of a newly reported error, lowest priority first.
   typedef enum logic [2:0] {
      KIND_CE, KIND_DE, KIND_RESTART, KIND_RECOVER, KIND_UNRECOV, KIND_UNCONT
   } eru_kind_t;

   // Priority rank of a reported kind; the empty record ranks zero.
   function automatic logic [2:0] eruRank(input eru_kind_t k);
      eruRank = 3'(k) + 3'h1;
   endfunction
endpackage

// ==== hdl/eru_ce_counter.sv ====
// Corrected error counter with unsigned wrap indication.
// Assumes a single increment strobe from logic on the same clock.
`timescale 1ns/1ns
module eru_ce_counter #(
   parameter int CNT_W = 8
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic inc,
   output logic [CNT_W-1:0] count_r,
   output logic wrapNext
);
   logic [CNT_W-1:0] count_nxt; // Next count value.

   // The next increment wraps when every bit is already one.
   assign wrapNext = &count_r;

   // Count one step per accepted increment; wrap is silent here.
   always_comb begin
      count_nxt = count_r;
      if (inc) begin
         count_nxt = count_r + CNT_W'(1);
      end
   end

   // Register the count.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         count_r <= '0;
      end else begin
         count_r <= count_nxt;
      end
   end
endmodule

// ==== hdl/eru_action_sel.sv ====
// Decides keep or overwrite, overflow and counting for one new error.
// Assumes the stored status fields are fed back from the record flops.
`timescale 1ns/1ns
module eru_action_sel
   import eru_pkg::*;
#(
   parameter bit HAS_CNT = 1'b1
) (
   input wire logic prevValid,
   input wire logic [1:0] prevCe,
   input wire logic prevPostponed,
   input wire logic prevUncorr,
   input wire logic [1:0] prevSub,
   input wire eru_kind_t newKind,
   input wire logic ceoOpt,
   input wire logic ofNow,
   output logic [2:0] prevRank,
   output logic overwrite,
   output logic setOf,
   output logic doCount
);
`include "eru_cfg.svh"

   // Decode the stored state and resolve the action table.
   always_comb begin
      prevRank = `ERU_RANK_NONE;
      if (prevValid) begin
         if (prevUncorr) begin
            case (prevSub)
               `ERU_SUB_RESTART: prevRank = eruRank(KIND_RESTART);
               `ERU_SUB_RECOVER: prevRank = eruRank(KIND_RECOVER);
               `ERU_SUB_UNRECOV: prevRank = eruRank(KIND_UNRECOV);
               default: prevRank = eruRank(KIND_UNCONT);
            endcase
         end else if (prevPostponed) begin
            prevRank = `ERU_RANK_DE;
         end else if (prevCe != 2'h0) begin
            prevRank = `ERU_RANK_CE;
         end
      end
      overwrite = 1'b1;
      setOf = 1'b0;
      doCount = 1'b0;
      if (prevRank == `ERU_RANK_NONE) begin
         doCount = HAS_CNT && (newKind == KIND_CE);
      end else if (newKind == KIND_CE) begin
         if (prevRank == `ERU_RANK_CE && HAS_CNT && ceoOpt) begin
            doCount = 1'b1;
            overwrite = !ofNow;
         end else begin
            overwrite = 1'b0;
            doCount = HAS_CNT;
            setOf = !HAS_CNT;
         end
      end else begin
         overwrite = eruRank(newKind) > prevRank;
         setOf = 1'b1;
      end
   end
endmodule

// ==== dv/eru_src_model.sv ====
// Model of the error-detecting components that report into the record.
// Assumes the bench calls send() once per source just after a falling edge.
`timescale 1ns/1ns
module eru_src_model #(
   parameter int NSRC = 2
) (
   output logic [NSRC-1:0] errValid,
   output logic [NSRC-1:0][2:0] errKind,
   output logic [NSRC-1:0][1:0] errCeVal,
   output logic [NSRC-1:0][7:0] errPrimaryCode,
   output logic [NSRC-1:0][7:0] errImplCode,
   output logic [NSRC-1:0][7:0] errArchCode,
   output logic [NSRC-1:0] errPoisonSeen,
   output logic [NSRC-1:0] errHasAddr,
   output logic [NSRC-1:0][31:0] errAddr,
   output logic [NSRC-1:0] errHasMisc,
   output logic [NSRC-1:0][31:0] errMisc,
   output logic [NSRC-1:0] errMiscUnrelated
);
   // All sources are quiet at time zero.
   initial begin
      {errValid, errKind, errCeVal, errPrimaryCode, errImplCode, errArchCode} = '0;
      {errPoisonSeen, errHasAddr, errAddr, errHasMisc, errMisc, errMiscUnrelated} = '0;
   end

   // one report per source
   // Fields always follow fresh words, so an idle source never shows stale data.
   task automatic send(input int i, input logic v, input logic [2:0] k,
                       input logic [31:0] r, input logic [31:0] s);
      errValid[i] = v;
      errKind[i] = v ? k : r[2:0];
      errCeVal[i] = r[1:0];
      errPrimaryCode[i] = r[9:2];
      errImplCode[i] = r[17:10];
      errArchCode[i] = r[25:18];
      errPoisonSeen[i] = r[26];
      errHasAddr[i] = r[27];
      errHasMisc[i] = r[28];
      errMiscUnrelated[i] = r[29];
      errAddr[i] = s;
      errMisc[i] = {s[15:0], r[31:16]};
   endtask
endmodule

// ==== dv/eru_record_test.sv ====
// Self-checking bench for the error record; a reference copy here predicts
// every field, misc only while known, half a cycle after each rising edge. Assumes the default parameters.
`timescale 1ns/1ns
`include "eru_cfg.svh"
module eru_record_test;
   logic clk_sys, rst, countedOverwriteOption, swStatusRead, swClear;
   logic [6:0] swClearMask;
   logic [1:0] errValid, errPoisonSeen, errHasAddr, errHasMisc, errMiscUnrelated;
   logic [1:0][2:0] errKind;
   logic [1:0][1:0] errCeVal;
   logic [1:0][7:0] errPrimaryCode, errImplCode, errArchCode;
   logic [1:0][31:0] errAddr, errMisc;
   logic statusValid_r, postponedFlag_r, uncorrectedFlag_r, overflowFlag_r, poisonSeen_r;
   logic addrValid_r, miscValid_r, clearIgnored_r;
   logic [1:0] ceField_r, uncorrectedSubtype_r;
   logic [7:0] primaryCode_r, implFaultCode_r, archFaultCode_r, ceCount_r;
   logic [31:0] addr_r, misc_r, timestamp_r;
   // Reference copy of the record; misc is only compared while it is known.
   logic eV, eDe, eUe, eOf, ePn, eAv, eMv, eIgn, miscKnown, touched;
   logic [1:0] eCe, eSub;
   logic [7:0] ePc, eIc, eAc, eCnt;
   logic [31:0] eAddr, eMisc, tsHold, seed;
   int mismatches = 0;
   int check_count = 0;
   int cycles = 0;
   int steps = 0; // Steps driven since reset release; sets the expected stamp.

   eru_src_model #(.NSRC(2)) u_src (.errValid, .errKind, .errCeVal, .errPrimaryCode,
      .errImplCode, .errArchCode, .errPoisonSeen, .errHasAddr, .errAddr, .errHasMisc,
      .errMisc, .errMiscUnrelated);
   eru_record u_dut (.clk_sys, .rst, .errValid, .errKind, .errCeVal, .errPrimaryCode,
      .errImplCode, .errArchCode, .errPoisonSeen, .errHasAddr, .errAddr, .errHasMisc,
      .errMisc, .errMiscUnrelated, .countedOverwriteOption, .swStatusRead, .swClear,
      .swClearMask, .statusValid_r, .ceField_r, .postponedFlag_r, .uncorrectedFlag_r,
      .uncorrectedSubtype_r, .overflowFlag_r, .primaryCode_r, .poisonSeen_r,
      .implFaultCode_r, .archFaultCode_r, .addrValid_r, .addr_r, .miscValid_r, .misc_r,
      .timestamp_r, .ceCount_r, .clearIgnored_r);

   // The clock toggles every half period of 4 ns.
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // The planned run is near 1060 cycles, so 5000 means a hang.
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches++;
         results();
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [1:0] subOf(input logic [2:0] k);
      case (k)
         3'h2: return `ERU_SUB_RESTART;
         3'h3: return `ERU_SUB_RECOVER;
         3'h4: return `ERU_SUB_UNRECOV;
         default: return `ERU_SUB_UNCONT;
      endcase
   endfunction

   function automatic int heldRank();
      if (!eV) return 0;
      if (eUe) return eSub == 2'h2 ? 3 : eSub == 2'h3 ? 4 : eSub == 2'h1 ? 5 : 6;
      if (eDe) return 2;
      return eCe != 2'h0 ? 1 : 0;
   endfunction

   task automatic chk(input logic ok, input string m);
      check_count++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask

   // Compares the record with the reference copy.
   task automatic check();
      chk({statusValid_r, ceField_r, postponedFlag_r, uncorrectedFlag_r} === {eV, eCe, eDe, eUe},
          "status flags");
      chk(uncorrectedSubtype_r === eSub, "subtype");
      chk(overflowFlag_r === eOf, "overflow");
      chk({primaryCode_r, implFaultCode_r, archFaultCode_r} === {ePc, eIc, eAc}, "codes");
      chk(poisonSeen_r === ePn, "poison");
      chk({addrValid_r, addr_r} === {eAv, eAddr}, "address");
      chk(miscValid_r === eMv && (!miscKnown || misc_r === eMisc), "misc");
      chk(ceCount_r === eCnt, "count");
      chk(clearIgnored_r === eIgn, "clear refusal");
      chk(timestamp_r === tsHold, "timestamp");
   endtask

   // One cycle: check the last result, then drive reports and software strobes.
   task automatic step(input logic [1:0] v, input logic [2:0] k0, input logic [2:0] k1,
                       input logic opt, input logic rd, input logic clr, input logic [6:0] m);
      int w, pr;
      logic [2:0] k;
      logic [31:0] r;
      logic ow, setOf;
      @(negedge clk_sys);
      check();
      steps++;
      for (int i = 0; i < 2; i++) begin
         seed = lfsr(seed);
         r = seed;
         seed = lfsr(seed);
         u_src.send(i, v[i], i ? k1 : k0, r, seed);
      end
      {countedOverwriteOption, swStatusRead, swClear, swClearMask} = {opt, rd, clr, m};
      w = -1;
      for (int i = 0; i < 2; i++)
         if (errValid[i] && (w < 0 || errKind[i] > errKind[w])) w = i;
      eIgn = 1'b0;
      if (clr && (touched || w >= 0)) eIgn = 1'b1;
      else if (clr) begin
         if (m[`ERU_CLR_VALID]) eV = 1'b0;
         if (m[`ERU_CLR_CE]) eCe = 2'h0;
         if (m[`ERU_CLR_POSTPONED]) eDe = 1'b0;
         if (m[`ERU_CLR_UNCORR]) eUe = 1'b0;
         if (m[`ERU_CLR_OVERFLOW]) eOf = 1'b0;
         if (m[`ERU_CLR_MISC]) eMv = 1'b0;
         if (m[`ERU_CLR_ADDR]) eAv = 1'b0;
      end
      // The read clears the guard only from the next edge on.
      if (rd) touched = 1'b0;
      if (w >= 0) begin
         k = errKind[w];
         pr = heldRank();
         touched = 1'b1;
         setOf = 1'b0;
         if (pr == 0) ow = 1'b1;
         else if (k == 3'h0) ow = pr == 1 && opt && !eOf;
         else begin
            ow = int'(k) + 1 > pr;
            setOf = 1'b1;
         end
         if (k == 3'h0) begin
            if (eCnt == 8'hFF) setOf = 1'b1;
            eCnt = eCnt + 8'h01;
         end
         if (setOf) eOf = 1'b1;
         if (k == 3'h0) eCe = errCeVal[w] != 2'h0 ? errCeVal[w] : `ERU_CE_DEFAULT;
         if (ow) begin
            eV = 1'b1;
            if (k == 3'h0) {eDe, eUe} = 2'h0;
            else if (k == 3'h1) {eDe, eUe} = 2'h2;
            else {eUe, eSub} = {1'b1, subOf(k)};
            {ePc, eIc, eAc} = {errPrimaryCode[w], errImplCode[w], errArchCode[w]};
            ePn = errPoisonSeen[w] && k != 3'h0;
            eAv = errHasAddr[w];
            if (eAv) eAddr = errAddr[w];
            eMv = 1'b1;
            // The time base is one at the first edge that takes a step's inputs.
            tsHold = 32'(steps);
            miscKnown = errHasMisc[w];
            if (miscKnown) eMisc = errMisc[w];
         end else begin
            if (k == 3'h1) eDe = 1'b1;
            if (k > 3'h1) eUe = 1'b1;
            if (errHasMisc[w]) {eMv, miscKnown, eMisc} = {2'h3, errMisc[w]};
         end
      end
   endtask

   task automatic clearRec();
      step(2'h0, 3'h0, 3'h0, 1'b0, 1'b1, 1'b0, 7'h00);
      step(2'h0, 3'h0, 3'h0, 1'b0, 1'b0, 1'b1, 7'h7F);
   endtask

   task automatic results();
      if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Main sequence: corner cases first, then a random mix.
   initial begin
      {countedOverwriteOption, swStatusRead, swClear, swClearMask, rst} = '1;
      {countedOverwriteOption, swStatusRead, swClear, swClearMask} = '0;
      {eV, eDe, eUe, eOf, ePn, eAv, eMv, eIgn, touched} = '0;
      {eCe, eSub, ePc, eIc, eAc, eCnt, eAddr, eMisc, tsHold} = '0;
      miscKnown = 1'b1;
      seed = 32'h0001_53F5;
      repeat (12) @(negedge clk_sys);
      rst = 1'b0;
      for (int k = 0; k < 6; k++) begin
         step(2'h1, 3'(k), 3'h0, 1'b0, 1'b0, 1'b0, 7'h00);
         step(2'h0, 3'h0, 3'h0, 1'b0, 1'b0, 1'b1, 7'h7F);
         clearRec();
      end
      for (int o = 0; o < 2; o++)
         for (int p = 0; p < 6; p++)
            for (int n = 0; n < 6; n++) begin
               step(2'h1, 3'(p), 3'h0, o[0], 1'b0, 1'b0, 7'h00);
               step(2'h2, 3'h0, 3'(n), o[0], 1'b0, 1'b0, 7'h00);
               step(2'h3, 3'(n), 3'(p), o[0], 1'b0, 1'b0, 7'h00);
               clearRec();
            end
      repeat (260) step(2'h1, 3'h0, 3'h0, 1'b1, 1'b0, 1'b0, 7'h00);
      repeat (400) begin
         seed = lfsr(seed);
         step(seed[1:0], seed[4:2] % 3'h6, seed[7:5] % 3'h6, seed[8],
              seed[1:0] == 2'h0 && seed[10:9] == 2'h1,
              seed[10:9] == 2'h2, seed[17:11]);
      end
      step(2'h0, 3'h0, 3'h0, 1'b0, 1'b0, 1'b0, 7'h00);
      results();
   end
endmodule
